// ### logic/bcrx_receiver.sv
// bi-phase command receiver top: window, half-cell demodulator and nrz output
`include "bcrx_regs.svh"
module bcrx_receiver #(
  parameter int unsigned WINDOW_CYC = `BCRX_WINDOW_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             cycle_start,
  input  wire logic             cmd_in,
  output bcrx_pkg::bcrx_nrz_t   nrz_out,
  output wire logic             cmd_window
);
  import bcrx_pkg::*;

  // ==========================================================
  // timing of the command path, in system clocks
  // - the pin meets a free-running flop, then the sampler and
  //   delayed stage on each 10 MHz step
  // - the edge filter needs a net run of four samples, so a clean
  //   edge reaches the filtered level some 60 to 70 clocks later
  // - the edge sync presets on a filtered edge and gives a
  //   half-cell pulse three steps after the preset
  // - further pulses follow every 100 clocks, mid half cell
  // - the difference flag trails a pulse by two clocks; its rise
  //   starts the load delay
  // - the nrz flop then takes the older tap, so a new bit shows
  //   only once both of its halves have been sampled
  // - the shift strobe rides every second pulse and restarts its
  //   phase when the nrz level moves
  // limits worth knowing
  // - noise netting four wrong samples in one half cell gets
  //   through; nothing later can repair it
  // - the path clears one clock after cmd_window falls, so a last
  //   strobe may show beside the falling window
  // - a second cycle start simply restarts the aperture count

  // ==========================================================
  // declarations
  bcrx_top_st_t s;
  bcrx_top_st_t next_s;
  logic         filtered;
  logic         sample_pulse;
  logic         diff_rise;
  logic         load_now;

  // ==========================================================
  // outputs, all straight from flops
  assign nrz_out.nrz   = s.nrz_output_ff;
  assign nrz_out.shift = s.shift_strobe;
  assign cmd_window    = s.window;

  // ==========================================================
  // edge filter and edge-locked timing
  bcrx_edge_filter u_filter (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (s.tick),
    .window   (s.window),
    .cmd_in   (cmd_in),
    .filtered (filtered)
  );

  bcrx_edge_sync u_sync (
    .clk          (clk),
    .rst_n        (rst_n),
    .tick         (s.tick),
    .window       (s.window),
    .filt_in      (filtered),
    .sample_pulse (sample_pulse)
  );

  // ==========================================================
  // load control terms
  // a fresh difference restarts the load delay; halves change only every 1 us so
  // the delay always completes before the taps move again
  assign diff_rise = s.halfcell_diff_gate & ~s.diff_prev;
  assign load_now  = (s.load_dly == 3'h1);

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;

    // 10 MHz step derived from the system clock
    if (s.tick_cnt == 4'(`BCRX_TICK_DIV - 1)) begin
      next_s.tick_cnt = 4'h0;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 4'h1;
      next_s.tick     = 1'b0;
    end

    // command window opens on each cycle start, closes after the aperture
    if (cycle_start) begin
      next_s.window  = 1'b1;
      next_s.win_cnt = '0;
    end else if (s.window) begin
      if (s.win_cnt == `BCRX_WIN_CNT_W'(WINDOW_CYC - 1)) begin
        next_s.window = 1'b0;
      end else begin
        next_s.win_cnt = s.win_cnt + `BCRX_WIN_CNT_W'(1);
      end
    end

    // half-cell samples at the 1 MHz edge-locked clock
    if (sample_pulse) begin
      next_s.halfcell_sample = {s.halfcell_sample[0], filtered};
    end

    // compare adjacent halves; no init needed, any reversal resyncs it
    next_s.halfcell_diff_gate = s.halfcell_sample[0] ^ s.halfcell_sample[1];
    next_s.diff_prev          = s.halfcell_diff_gate;

    // nrz load after the set-up delay, from the older tap
    next_s.shift_strobe = 1'b0;
    if (diff_rise) begin
      next_s.load_dly = 3'(`BCRX_LOAD_DLY_CYC);
    end else if (s.load_dly != 3'h0) begin
      next_s.load_dly = s.load_dly - 3'h1;
    end
    if (load_now) begin
      next_s.nrz_output_ff = s.halfcell_sample[1];
    end

    // bit strobe: every second half-cell pulse, realigned when the nrz level moves
    if (load_now && s.halfcell_sample[1] != s.nrz_output_ff) begin
      next_s.bit_phase = 1'b0;
    end else if (sample_pulse) begin
      next_s.bit_phase    = ~s.bit_phase;
      next_s.shift_strobe = s.bit_phase;
    end

    // outside the aperture everything on the command path sits clear
    if (!s.window) begin
      next_s.halfcell_sample    = 2'h0;
      next_s.halfcell_diff_gate = 1'b0;
      next_s.diff_prev          = 1'b0;
      next_s.load_dly           = 3'h0;
      next_s.nrz_output_ff      = 1'b0;
      next_s.bit_phase          = 1'b0;
      next_s.shift_strobe       = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // window must open the cycle after a start pulse
  chk_window_open: assert property (
    cycle_start |=> s.window && s.win_cnt == '0)
    else $error("window did not open after cycle start");

  // window closes exactly at the end of the aperture
  chk_window_close: assert property (
    (s.window && !cycle_start && s.win_cnt == `BCRX_WIN_CNT_W'(WINDOW_CYC - 1))
      |=> !s.window)
    else $error("window overran the aperture");

  // window stays open until the count is reached
  chk_window_hold: assert property (
    (s.window && s.win_cnt < `BCRX_WIN_CNT_W'(WINDOW_CYC - 1)) |=> s.window)
    else $error("window closed early");

  // the closed window keeps the output clear
  chk_closed_clear: assert property (
    !s.window |=> !s.nrz_output_ff && !s.shift_strobe)
    else $error("nrz path active outside the window");

  // the 10 MHz step repeats every divider period
  chk_tick_period: assert property (
    s.tick |=> !s.tick [*8] ##1 !s.tick ##1 s.tick)
    else $error("sampling step is not 10 MHz");

  // difference flag follows the two taps
  chk_diff_taps: assert property (
    s.window && $past(s.window) |->
      s.halfcell_diff_gate == ($past(s.halfcell_sample[0]) ^ $past(s.halfcell_sample[1])))
    else $error("half-cell difference flag wrong");

  // a rising difference reaches the load point after the fixed delay
  chk_load_delay: assert property (
    (diff_rise && s.window) |=> (s.load_dly == 3'h5) ##4 (load_now || !s.window))
    else $error("nrz load delay wrong");

  // loaded value is the older half-cell sample
  chk_load_value: assert property (
    (load_now && s.window) |=> s.nrz_output_ff == $past(s.halfcell_sample[1]))
    else $error("nrz loaded from the wrong tap");

  // nrz only moves at a load point
  chk_nrz_stable: assert property (
    (!load_now && s.window) |=> $stable(s.nrz_output_ff))
    else $error("nrz changed without a load");

  // strobe is one cycle wide
  chk_strobe_width: assert property (
    s.shift_strobe |=> !s.shift_strobe)
    else $error("shift strobe longer than one cycle");

  // strobe comes only from a half-cell sample pulse
  chk_strobe_cause: assert property (
    s.shift_strobe |-> $past(sample_pulse) && $past(s.bit_phase))
    else $error("shift strobe without sample pulse");

  // step flag marks the wrap of the divider
  chk_tick_phase: assert property (
    s.tick |-> s.tick_cnt == 4'h0)
    else $error("sampling step off its divider wrap");

  // aperture count never passes its last value
  chk_win_cnt_bound: assert property (
    s.window |-> s.win_cnt <= `BCRX_WIN_CNT_W'(WINDOW_CYC - 1))
    else $error("aperture count out of range");

  // a shut window stays shut without a start
  chk_window_idle: assert property (
    (!s.window && !cycle_start) |=> !s.window)
    else $error("window opened without cycle start");

  // no half-cell pulse outside the aperture
  chk_sample_closed: assert property (
    !s.window |=> !sample_pulse)
    else $error("sample pulse outside the window");

  // filtered level held clear outside the aperture
  chk_filtered_closed: assert property (
    !s.window |=> !filtered)
    else $error("filtered level set outside the window");

  // half-cell taps held clear outside the aperture
  chk_halfcell_closed: assert property (
    !s.window |=> s.halfcell_sample == 2'h0 && !s.halfcell_diff_gate)
    else $error("half-cell taps set outside the window");

  // load delay held idle outside the aperture
  chk_load_closed: assert property (
    !s.window |=> s.load_dly == 3'h0)
    else $error("load delay running outside the window");

  // half-cell pulses come only from a 10 MHz step
  chk_sample_on_tick: assert property (
    sample_pulse |-> $past(s.tick))
    else $error("sample pulse without a step");

  // half-cell pulse is one cycle wide
  chk_sample_single: assert property (
    sample_pulse |=> !sample_pulse)
    else $error("sample pulse longer than one cycle");

  // a pulse shifts the filtered level into the taps
  chk_halfcell_shift: assert property (
    (sample_pulse && s.window) |=>
      s.halfcell_sample == {$past(s.halfcell_sample[0]), $past(filtered)})
    else $error("half-cell taps did not shift");

  // taps hold between pulses
  chk_halfcell_hold: assert property (
    (!sample_pulse && s.window) |=> $stable(s.halfcell_sample))
    else $error("half-cell taps moved without a pulse");

  // previous flag trails the difference flag by one clock
  chk_diff_prev: assert property (
    s.window && $past(s.window) |-> s.diff_prev == $past(s.halfcell_diff_gate))
    else $error("difference edge detector wrong");

  // load delay never exceeds its start value
  chk_load_bound: assert property (
    s.load_dly <= 3'(`BCRX_LOAD_DLY_CYC))
    else $error("load delay out of range");

  // an nrz change restarts the bit phase
  chk_strobe_realign: assert property (
    (load_now && s.window && s.halfcell_sample[1] != s.nrz_output_ff)
      |=> !s.bit_phase && !s.shift_strobe)
    else $error("bit phase not realigned on nrz change");

  // each ordinary pulse flips the bit phase
  chk_phase_toggle: assert property (
    (sample_pulse && s.window && !load_now) |=> s.bit_phase != $past(s.bit_phase))
    else $error("bit phase did not toggle");

  // a strobe needs an open window one cycle before
  chk_shift_needs_window: assert property (
    s.shift_strobe |-> $past(s.window))
    else $error("strobe without an open window");

  // a set nrz bit needs an open window one cycle before
  chk_nrz_needs_window: assert property (
    s.nrz_output_ff |-> $past(s.window))
    else $error("nrz set without an open window");

  // ==========================================================
  // scenario coverage
  cov_filtered_rise: cover property (s.window && $rose(filtered));
  cov_nrz_one:       cover property (load_now ##1 s.nrz_output_ff);
  cov_bit_strobe:    cover property (s.shift_strobe && s.nrz_output_ff);
  cov_window_end:    cover property ($fell(s.window));
  cov_window_again:  cover property (cycle_start && s.window);

endmodule : bcrx_receiver

// ### logic/bcrx_regs.svh
// constants of the bi-phase command receiver
//
// Summary of operation
// - Detection logic runs only in the first 1000 us after a cycle start and is held clear otherwise.
// - Each input decision is caught in a sampling flop and a delayed stage; the delayed stage alone sets the filter shift direction.
// - The four-stage edge filter shifts a one in at the first stage on a one and a zero in at the last on a zero.
// - The edge filter holds all ones, all zeros or one single boundary, clears only on reset or a shut window, and never loads.
// - The filtered level sets when a one reaches the last stage and clears when a zero reaches the first stage.
// - The filtered level changes only after a net run of four new samples, each opposing one adding one more.
// - The 500 kHz bi-phase stream is sampled once per half cell and successive halves are compared.
// - Filtered data shifts through a half-cell sample register at 1 MHz and an xor flags unequal adjacent halves.
// - A rising difference flag loads the NRZ flop, after a short delay, from the tap one microsecond older.
// - Demodulation needs no start-up sequence; data transitions alone bring the output right.
// - A control counter locked to the bit edges makes the sampling, demodulator and NRZ load timing.
// - Sampling and edge detection advance at 10 MHz, a 100 ns step.
// - The edge counter presets to 5 on each edge and cycles 5 to 9, giving a 1 MHz sample mid half cell.
`ifndef BCRX_REGS_SVH
`define BCRX_REGS_SVH

// ==========================================================
// clocking
`define BCRX_CLK_HZ        100000000
`define BCRX_TICK_HZ       10000000
`define BCRX_TICK_DIV      (`BCRX_CLK_HZ / `BCRX_TICK_HZ)

// ==========================================================
// command window
`define BCRX_WINDOW_US     1000
`define BCRX_WINDOW_CYC    (`BCRX_WINDOW_US * (`BCRX_CLK_HZ / 1000000))
`define BCRX_WIN_CNT_W     17

// ==========================================================
// nrz load delay, least time so rounded up
`define BCRX_LOAD_DLY_NS   45
`define BCRX_LOAD_DLY_CYC  ((`BCRX_LOAD_DLY_NS * (`BCRX_CLK_HZ / 1000000) + 999) / 1000)

// ==========================================================
// edge filter and edge sync counter
`define BCRX_FILT_W        4
`define BCRX_FILT_RESET    4'h0
`define BCRX_SYNC_PRESET   4'h5
`define BCRX_SYNC_LAST     4'h9
`define BCRX_SYNC_TOGGLE   4'h7

`endif

// ### logic/bcrx_pkg.sv
// types of the bi-phase command receiver
`include "bcrx_regs.svh"
package bcrx_pkg;

  // ==========================================================
  // filter shift direction
  typedef enum logic {BCRX_SHIFT_LEFT, BCRX_SHIFT_RIGHT} bcrx_shift_t;

  // ==========================================================
  // recovered data towards the start detector
  typedef struct packed {
    logic nrz;
    logic shift;
  } bcrx_nrz_t;

  // ==========================================================
  // edge filter state
  typedef struct packed {
    logic                    sync_ff;
    logic                    input_sampler_ff;
    logic                    delayed_ff;
    logic [`BCRX_FILT_W-1:0] edge_fuzz_integrator;
    logic                    filtered_data_ff;
  } bcrx_filt_st_t;

  // ==========================================================
  // edge sync counter state
  typedef struct packed {
    logic [1:0] edge_detect_reg;
    logic [3:0] edge_sync_counter;
    logic       phase_toggle;
    logic       sample_pulse;
  } bcrx_sync_st_t;

  // ==========================================================
  // top level state
  typedef struct packed {
    logic [3:0]                 tick_cnt;
    logic                       tick;
    logic                       window;
    logic [`BCRX_WIN_CNT_W-1:0] win_cnt;
    logic [1:0]                 halfcell_sample;
    logic                       halfcell_diff_gate;
    logic                       diff_prev;
    logic [2:0]                 load_dly;
    logic                       nrz_output_ff;
    logic                       bit_phase;
    logic                       shift_strobe;
  } bcrx_top_st_t;

endpackage : bcrx_pkg

// ### logic/bcrx_edge_filter.sv
// input sampler and four-stage edge fuzz integrator
`include "bcrx_regs.svh"
module bcrx_edge_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic window,
  input  wire logic cmd_in,
  output wire logic filtered
);
  import bcrx_pkg::*;

  bcrx_filt_st_t s;
  bcrx_filt_st_t next_s;
  logic          filter_mode_sel_hi;
  logic          filter_mode_sel_lo;
  logic          filter_first_stage;
  logic          filter_last_stage;
  logic          right_fill_input;
  logic          left_fill_input;
  bcrx_shift_t   mode;

  // ==========================================================
  // mode select: the delayed stage and its complement, so 00 and 11 never arise
  assign filter_mode_sel_hi = s.delayed_ff;
  assign filter_mode_sel_lo = ~s.delayed_ff;
  assign mode               = bcrx_shift_t'(filter_mode_sel_hi & ~filter_mode_sel_lo);
  assign filter_first_stage = s.edge_fuzz_integrator[0];
  assign filter_last_stage  = s.edge_fuzz_integrator[`BCRX_FILT_W-1];
  assign right_fill_input   = 1'b1;
  assign left_fill_input    = 1'b0;
  assign filtered           = s.filtered_data_ff;

  // ==========================================================
  // next state; the first synchroniser flop runs every clock, the rest at 10 MHz
  always_comb begin
    next_s         = s;
    next_s.sync_ff = cmd_in;
    if (tick) begin
      next_s.input_sampler_ff = s.sync_ff;
      next_s.delayed_ff       = s.input_sampler_ff;
      // no data path through the register, only fill bits move
      unique case (mode)
        BCRX_SHIFT_RIGHT: next_s.edge_fuzz_integrator =
          {s.edge_fuzz_integrator[`BCRX_FILT_W-2:0], right_fill_input};
        BCRX_SHIFT_LEFT:  next_s.edge_fuzz_integrator =
          {left_fill_input, s.edge_fuzz_integrator[`BCRX_FILT_W-1:1]};
      endcase
      if (filter_last_stage) begin
        next_s.filtered_data_ff = 1'b1;
      end else if (!filter_first_stage) begin
        next_s.filtered_data_ff = 1'b0;
      end
    end
    // closed window holds the detection registers clear
    if (!window) begin
      next_s.input_sampler_ff     = 1'b0;
      next_s.delayed_ff           = 1'b0;
      next_s.edge_fuzz_integrator = `BCRX_FILT_RESET;
      next_s.filtered_data_ff     = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_filter_one_boundary: assert property (
    s.edge_fuzz_integrator inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("edge filter holds more than one boundary");

  chk_filter_set_cause: assert property (
    $rose(s.filtered_data_ff) |-> $past(s.edge_fuzz_integrator) == 4'hF)
    else $error("filtered level rose without a full run of ones");

  chk_filter_run_four: assert property (
    (window && tick && s.edge_fuzz_integrator == 4'h0 && !s.filtered_data_ff)
      |=> !s.filtered_data_ff)
    else $error("filtered level rose before four samples");

endmodule : bcrx_edge_filter

// ### logic/bcrx_edge_sync.sv
// edge-locked demodulation control counter
`include "bcrx_regs.svh"
module bcrx_edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic window,
  input  wire logic filt_in,
  output wire logic sample_pulse
);
  import bcrx_pkg::*;

  bcrx_sync_st_t s;
  bcrx_sync_st_t next_s;
  logic          edge_seen;

  assign edge_seen    = s.edge_detect_reg[1] ^ s.edge_detect_reg[0];
  assign sample_pulse = s.sample_pulse;

  // ==========================================================
  // 5..9 counter gives 2 MHz; the toggle halves it to the 1 MHz half-cell clock
  always_comb begin
    next_s              = s;
    next_s.sample_pulse = 1'b0;
    if (tick) begin
      next_s.edge_detect_reg = {s.edge_detect_reg[0], filt_in};
      if (edge_seen) begin
        next_s.edge_sync_counter = `BCRX_SYNC_PRESET;
        next_s.phase_toggle      = 1'b0;
      end else begin
        if (s.edge_sync_counter == `BCRX_SYNC_LAST) begin
          next_s.edge_sync_counter = `BCRX_SYNC_PRESET;
        end else begin
          next_s.edge_sync_counter = s.edge_sync_counter + 4'h1;
        end
        if (s.edge_sync_counter == `BCRX_SYNC_TOGGLE) begin
          next_s.phase_toggle = ~s.phase_toggle;
          next_s.sample_pulse = ~s.phase_toggle;
        end
      end
    end
    if (!window) begin
      next_s                   = '0;
      next_s.edge_sync_counter = `BCRX_SYNC_PRESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s                   <= '0;
      s.edge_sync_counter <= `BCRX_SYNC_PRESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sync_range: assert property (
    s.edge_sync_counter inside {[4'h5:4'h9]})
    else $error("edge sync counter left its 5..9 range");

  chk_sync_preset_edge: assert property (
    (window && tick && edge_seen) |=> s.edge_sync_counter == 4'h5 && !s.phase_toggle)
    else $error("edge did not preset the sync counter");

endmodule : bcrx_edge_sync

// ### test/bcrx_sender_model.sv
// partner model: bi-phase command sender as seen through the line comparator
module bcrx_sender_model (
  input  wire logic clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // line state
  // no pull on this line, so a released line shows the inverse of the last half
  initial line = 1'b0;

  // ==========================================================
  // timing helpers
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  // one half cell of 100 clocks; bounce and glitch stay under four samples
  task automatic send_half(input logic v, input logic bnc, input logic gl);
    line = v;
    if (bnc) begin
      wait_clk(10);
      line = ~v;
      wait_clk(10);
      line = v;
      wait_clk(20);
    end else begin
      wait_clk(40);
    end
    if (gl) begin
      line = ~v;
      wait_clk(30);
      line = v;
      wait_clk(30);
    end else begin
      wait_clk(60);
    end
  endtask : send_half

  // ==========================================================
  // bit and message level
  // first half carries the bit, second its complement
  task automatic send_bit(input logic b, input logic bnc, input logic gl);
    send_half(b, bnc, gl);
    send_half(~b, bnc, gl);
  endtask : send_bit

  task automatic send_preamble(input int n);
    repeat (n) send_bit(1'b0, 1'b0, 1'b0);
  endtask : send_preamble

  task automatic release_line();
    line = ~line;
  endtask : release_line

endmodule : bcrx_sender_model

// ### test/testbench.sv
// self-checking testbench of the bi-phase command receiver
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bcrx_pkg::*;

  // ==========================================================
  // signals and bookkeeping
  localparam int WIN = 25000;  // short window keeps the run small
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cycle_start = 1'b0;
  logic       cmd_in;
  bcrx_nrz_t  nrz_out;
  logic       cmd_window;
  int         err_total = 0;
  int         checks = 0;
  int         seed = 46;
  int         cyc = 0;
  int         win_hi = 0;
  int         lst = 0;
  logic       exp_q[$];
  logic       nrz_q = 1'b0;
  logic       last_b = 1'b0;
  logic       sp_on = 1'b0;
  logic       sp_prev = 1'b0;
  logic       chg = 1'b0;
  logic       win_q = 1'b0;

  always #5 clk = ~clk;

  always @(posedge clk) cyc++;

  bcrx_receiver #(.WINDOW_CYC(WIN)) u_dut (
    .clk         (clk),
    .rst_n       (rst_n),
    .cycle_start (cycle_start),
    .cmd_in      (cmd_in),
    .nrz_out     (nrz_out),
    .cmd_window  (cmd_window)
  );

  bcrx_sender_model u_snd (
    .clk  (clk),
    .line (cmd_in)
  );

  // ==========================================================
  // shared tasks
  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : compare

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic pulse_start();
    cycle_start = 1'b1;
    step(1);
    cycle_start = 1'b0;
  endtask : pulse_start

  // bounded wait for the aperture to close; running out is a mismatch
  task automatic wait_closed();
    int i;
    for (i = 0; i < WIN + 50 && cmd_window === 1'b1; i++) step(1);
    if (cmd_window !== 1'b0) begin
      compare("window close wait", 1, 0);
      print_verdict();
    end
  endtask : wait_closed

  // a change of bit value is the only thing that may move the nrz output
  task automatic send(input logic b, input logic bnc, input logic gl);
    if (b !== last_b) exp_q.push_back(b);
    last_b = b;
    u_snd.send_bit(b, bnc, gl);
  endtask : send

  // ==========================================================
  // output watcher: takes the oldest note whenever the nrz level moves
  always @(negedge clk) begin
    if (rst_n) begin
      if (cmd_window === 1'b1) win_hi++;
      if (nrz_out.nrz !== nrz_q) begin
        chg = 1'b1;
        if (exp_q.size() == 0)
          compare("nrz spurious", nrz_out.nrz, nrz_q);
        else
          compare("nrz", nrz_out.nrz, exp_q.pop_front());
      end
      nrz_q = nrz_out.nrz;
      // the path clears one clock after the window flag falls
      if (cmd_window !== 1'b1 && win_q !== 1'b1) begin
        compare("nrz closed", nrz_out.nrz, 0);
        compare("shift closed", nrz_out.shift, 0);
      end
      win_q = cmd_window;
      // strobe spacing only judged on a clean stream with no realignment between
      if (nrz_out.shift === 1'b1) begin
        if (sp_on && sp_prev && !chg) compare("strobe gap", cyc - lst, 200);
        lst = cyc;
        sp_prev = sp_on;
        chg = 1'b0;
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    int i;
    logic bb;
    step(20);
    rst_n = 1'b1;
    // aperture length with a restart 301 edges after the first opening
    win_hi = 0;
    pulse_start();
    step(300);
    pulse_start();
    wait_closed();
    step(5);
    compare("window cycles", win_hi, 301 + WIN);
    $display("window test done");
    // message inside the aperture, no start-up sequence before the preamble
    pulse_start();
    step(20);
    last_b = 1'b0;
    u_snd.send_preamble(16);
    sp_on = 1'b1;
    for (i = 0; i < 40; i++) send(1'($random(seed)), 1'b0, 1'b0);
    sp_on = 1'b0;
    // edge fuzz and short glitches must be absorbed by the filter;
    // both in one half cell net under four true samples, so never together
    for (i = 0; i < 40; i++) begin
      bb = 1'($random(seed));
      send(1'($random(seed)), bb, ~bb & 1'($random(seed)));
    end
    for (i = 0; i < 8; i++) send(1'b0, 1'b0, 1'b0);
    u_snd.release_line();
    step(400);
    compare("notes left", exp_q.size(), 0);
    $display("message test done");
    // traffic while the aperture is shut must leave no trace
    wait_closed();
    for (i = 0; i < 12; i++) u_snd.send_bit(1'b1, 1'b0, 1'b0);
    step(50);
    compare("closed nrz", nrz_out.nrz, 0);
    $display("closed window test done");
    print_verdict();
  end

endmodule : testbench
